// ---- ihs_client_model.sv ----
`default_nettype none
// ==================================================
// client on the wire: acks written bytes, sends bytes on reads
module ihs_client_model (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic        nack,
  input  wire logic [15:0] stretch_ns,
  input  wire logic [7:0]  tx_byte,
  output var  logic        scl_pull,
  output var  logic        sda_pull,
  output var  logic [7:0]  rx_byte,
  output var  logic        host_ack,
  output var  logic [7:0]  n_starts
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] bit_cnt;
  logic [7:0] shift_q;
  logic       first_q;
  logic       read_q;
  // lines released at time zero
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    rx_byte  = 8'h00;
    host_ack = 1'b1;
    n_starts = 8'h00;
    bit_cnt  = 4'h0;
    shift_q  = 8'h00;
    first_q  = 1'b1;
    read_q   = 1'b0;
  end
  // data edge with clock high frames a transfer
  always @(sda) begin
    if (scl === 1'b1) begin
      bit_cnt  = 4'h0;
      first_q  = 1'b1;
      read_q   = 1'b0;
      sda_pull = 1'b0;
      if (sda === 1'b0)
        n_starts = n_starts + 8'h01;
    end
  end
  // sample on clock rise; ninth bit of a read is the host's answer
  always @(posedge scl) begin
    if (bit_cnt < 4'h8)
      shift_q = {shift_q[6:0], sda};
    else if (read_q && !first_q)
      host_ack = sda;
    bit_cnt = bit_cnt + 4'h1;
  end
  // drive after clock fall, then optionally hold the clock low
  always @(negedge scl) begin
    if (bit_cnt == 4'h8) begin
      if (first_q)
        read_q = shift_q[0];
      if (first_q || !read_q)
        rx_byte = shift_q;
      sda_pull = (first_q || !read_q) && !nack;
    end else if (bit_cnt == 4'h9) begin
      bit_cnt  = 4'h0;
      sda_pull = read_q && (first_q || !host_ack) && !tx_byte[7];
      first_q  = 1'b0;
    end else if (read_q && !first_q && bit_cnt != 4'h0) begin
      sda_pull = !tx_byte[3'h7 - bit_cnt[2:0]];
    end
    if (stretch_ns != 16'h0000) begin
      scl_pull = 1'b1;
      #(stretch_ns);
      scl_pull = 1'b0;
    end
  end
endmodule // ihs_client_model
`default_nettype wire

// ---- ihs_host_sequencer.sv ----
`include "ihs_params.svh"
`default_nettype none
module ihs_host_sequencer (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       scl_oe,
  output var  logic       sda_oe
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  wire        scl_s = scl_sync_q[1];
  wire        sda_s = sda_sync_q[1];

  // two flops per pin before any logic looks at it
  always_ff @(posedge clock) begin
    scl_sync_q <= {scl_sync_q[0], scl_in};
    sda_sync_q <= {sda_sync_q[0], sda_in};
  end

  // ==========================================================
  // registers and state
  ihs_pkg::ihs_state_type st_q, st_d;
  logic [7:0] tx_rx_buffer_q;
  logic [7:0] baud_reload_value_q;
  logic [4:0] req_q;
  logic       ack_value_to_send_q;
  logic       buffer_full_flag_q;
  logic       write_collision_flag_q;
  logic       received_ack_status_q;
  logic       serial_event_flag_q;
  logic       bus_collision_flag_q;
  logic       start_seen_q;
  logic       stop_seen_q;
  logic [7:0] cnt_q, cnt_d;
  logic       armed_q, armed_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic       scl_d, sda_d;
  logic [7:0] rd_mux;
  logic       enter, arm_ok, collide;
  logic       ev_set, ss_set, ps_set, ack_ld, full_clr, rx_done;
  logic [4:0] clr_req;

  // ==========================================================
  // bus decode
  wire busy      = (st_q != ihs_pkg::ST_IDLE) || (|req_q);
  wire wr_buf    = wr && (addr == `IHS_OFS_BUF);
  wire wr_ctrl   = wr && (addr == `IHS_OFS_CTRL);
  wire wr_stat   = wr && (addr == `IHS_OFS_STAT);
  wire buf_ok    = wr_buf && !busy;
  wire buf_col   = wr_buf && busy;
  wire ctrl_ok   = wr_ctrl && !busy;
  wire tmo       = armed_q && (cnt_q == `IHS_CNT_ZERO);
  wire rise      = !armed_q && arm_ok;
  wire [7:0] w1c = wr_stat ? wdata : `IHS_BYTE_RST;

  // read mux
  always_comb begin
    case (addr)
      `IHS_OFS_BUF:    rd_mux = tx_rx_buffer_q;
      `IHS_OFS_RELOAD: rd_mux = baud_reload_value_q;
      `IHS_OFS_CTRL:   rd_mux = {2'h0, ack_value_to_send_q, req_q};
      default:         rd_mux = {1'h0, stop_seen_q, start_seen_q, bus_collision_flag_q, serial_event_flag_q,
                                 received_ack_status_q, write_collision_flag_q, buffer_full_flag_q};
    endcase
  end

  // condition that lets the counter start in each state
  always_comb begin
    case (st_q)
      ihs_pkg::ST_R1:     arm_ok = !scl_s;
      ihs_pkg::ST_P1:     arm_ok = !sda_s;
      ihs_pkg::ST_P3:     arm_ok = sda_s && scl_s;
      ihs_pkg::ST_IDLE:   arm_ok = 1'b0;
      ihs_pkg::ST_TXHIGH, ihs_pkg::ST_RXHIGH,
      ihs_pkg::ST_R2, ihs_pkg::ST_A2,
      ihs_pkg::ST_P2:     arm_ok = scl_s;
      default:            arm_ok = 1'b1;
    endcase
  end

  // ==========================================================
  // sequencer
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    shift_d = shift_q;
    scl_d = scl_oe;
    sda_d = sda_oe;
    enter = 1'b0;
    collide = 1'b0;
    ev_set = 1'b0;
    ss_set = 1'b0;
    ps_set = 1'b0;
    ack_ld = 1'b0;
    full_clr = 1'b0;
    rx_done = 1'b0;
    clr_req = `IHS_REQ_RST;
    armed_d = armed_q;
    cnt_d = cnt_q;
    // counter runs from reload down to zero, held at reload while waiting
    if (tmo) begin
      cnt_d = cnt_q;
    end else if (armed_q) begin
      cnt_d = cnt_q - 8'h01;
    end else begin
      cnt_d = baud_reload_value_q;
      armed_d = arm_ok;
    end
    case (st_q)
      ihs_pkg::ST_IDLE: begin
        armed_d = 1'b0;
        if (req_q[`IHS_REQ_START]) begin
          if (scl_s && sda_s) begin
            st_d = ihs_pkg::ST_START1;
            enter = 1'b1;
          end else begin
            collide = 1'b1;
          end
        end else if (req_q[`IHS_REQ_RESTRT]) begin
          scl_d = 1'b1;
          st_d = ihs_pkg::ST_R1;
          enter = 1'b1;
        end else if (req_q[`IHS_REQ_STOP]) begin
          sda_d = 1'b1;
          st_d = ihs_pkg::ST_P1;
          enter = 1'b1;
        end else if (req_q[`IHS_REQ_RECV]) begin
          scl_d = 1'b1;
          sda_d = 1'b0;
          bit_d = `IHS_FIRST_BIT;
          st_d = ihs_pkg::ST_RXLOW;
          enter = 1'b1;
        end else if (req_q[`IHS_REQ_ACK]) begin
          scl_d = 1'b1;
          sda_d = !ack_value_to_send_q;
          st_d = ihs_pkg::ST_A1;
          enter = 1'b1;
        end else if (buf_ok) begin
          scl_d = 1'b1;
          shift_d = wdata;
          bit_d = `IHS_FIRST_BIT;
          st_d = ihs_pkg::ST_TXLOW;
          enter = 1'b1;
        end
      end
      ihs_pkg::ST_START1: begin
        if (!scl_s) begin
          collide = 1'b1;
        end else if (tmo) begin
          if (sda_s) begin
            sda_d = 1'b1;
            ss_set = 1'b1;
            st_d = ihs_pkg::ST_START2;
            enter = 1'b1;
          end else begin
            collide = 1'b1;
          end
        end
      end
      ihs_pkg::ST_START2: if (tmo) begin
        clr_req[`IHS_REQ_START] = 1'b1;
        ev_set = 1'b1;
        st_d = ihs_pkg::ST_IDLE;
      end
      ihs_pkg::ST_R1: begin
        if (rise) begin
          sda_d = 1'b0;
        end
        if (tmo) begin
          if (sda_s) begin
            scl_d = 1'b0;
            st_d = ihs_pkg::ST_R2;
            enter = 1'b1;
          end else begin
            collide = 1'b1;
          end
        end
      end
      ihs_pkg::ST_R2: begin
        if ((rise && !sda_s) || (armed_q && !scl_s)) begin
          collide = 1'b1;
        end else if (tmo) begin
          sda_d = 1'b1;
          ss_set = 1'b1;
          st_d = ihs_pkg::ST_R3;
          enter = 1'b1;
        end
      end
      ihs_pkg::ST_R3: if (tmo) begin
        scl_d = 1'b1;
        clr_req[`IHS_REQ_RESTRT] = 1'b1;
        ev_set = 1'b1;
        st_d = ihs_pkg::ST_IDLE;
      end
      ihs_pkg::ST_TXLOW, ihs_pkg::ST_RXLOW: begin
        // next bit goes out one cycle after the clock fell, never on the same edge
        if (st_q == ihs_pkg::ST_TXLOW && !armed_q) begin
          sda_d = (bit_q == `IHS_ACK_BIT) ? 1'b0 : !shift_q[7];
        end
        if (tmo) begin
          scl_d = 1'b0;
          st_d = (st_q == ihs_pkg::ST_TXLOW) ? ihs_pkg::ST_TXHIGH : ihs_pkg::ST_RXHIGH;
          enter = 1'b1;
        end
      end
      ihs_pkg::ST_TXHIGH: begin
        if (rise && (bit_q == `IHS_ACK_BIT)) begin
          ack_ld = 1'b1;
        end
        if (tmo) begin
          scl_d = 1'b1;
          if (bit_q == `IHS_ACK_BIT) begin
            ev_set = 1'b1;
            st_d = ihs_pkg::ST_IDLE;
          end else begin
            bit_d = bit_q + 4'h1;
            shift_d = {shift_q[6:0], 1'b0};
            full_clr = (bit_q == `IHS_LAST_BIT);
            st_d = ihs_pkg::ST_TXLOW;
            enter = 1'b1;
          end
        end
      end
      ihs_pkg::ST_RXHIGH: begin
        if (rise) begin
          shift_d = {shift_q[6:0], sda_s};
        end
        if (tmo) begin
          scl_d = 1'b1;
          if (bit_q == `IHS_LAST_BIT) begin
            rx_done = 1'b1;
            clr_req[`IHS_REQ_RECV] = 1'b1;
            ev_set = 1'b1;
            st_d = ihs_pkg::ST_IDLE;
          end else begin
            bit_d = bit_q + 4'h1;
            st_d = ihs_pkg::ST_RXLOW;
            enter = 1'b1;
          end
        end
      end
      ihs_pkg::ST_A1: if (tmo) begin
        scl_d = 1'b0;
        st_d = ihs_pkg::ST_A2;
        enter = 1'b1;
      end
      ihs_pkg::ST_A2: if (tmo) begin
        scl_d = 1'b1;
        clr_req[`IHS_REQ_ACK] = 1'b1;
        ev_set = 1'b1;
        st_d = ihs_pkg::ST_IDLE;
      end
      ihs_pkg::ST_P1: if (tmo) begin
        scl_d = 1'b0;
        st_d = ihs_pkg::ST_P2;
        enter = 1'b1;
      end
      ihs_pkg::ST_P2: if (tmo) begin
        sda_d = 1'b0;
        st_d = ihs_pkg::ST_P3;
        enter = 1'b1;
      end
      ihs_pkg::ST_P3: begin
        ps_set = rise;
        if (tmo) begin
          clr_req[`IHS_REQ_STOP] = 1'b1;
          ev_set = 1'b1;
          st_d = ihs_pkg::ST_IDLE;
        end
      end
      default: st_d = ihs_pkg::ST_IDLE;
    endcase
    // a collision drops both lines and every request
    if (collide) begin
      scl_d = 1'b0;
      sda_d = 1'b0;
      clr_req = 5'h1F;
      full_clr = 1'b1;
      st_d = ihs_pkg::ST_IDLE;
    end
    if (enter) begin
      cnt_d = baud_reload_value_q;
      armed_d = 1'b0;
    end
  end

  // ==========================================================
  // state, counter and pin drivers
  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= ihs_pkg::ST_IDLE;
      cnt_q <= `IHS_CNT_ZERO;
      armed_q <= 1'b0;
      bit_q <= `IHS_FIRST_BIT;
      shift_q <= `IHS_BYTE_RST;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      scl_oe <= scl_d;
      sda_oe <= sda_d;
    end
  end

  // software registers; requests only accepted while nothing is running
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_rx_buffer_q <= `IHS_BYTE_RST;
      baud_reload_value_q <= `IHS_RELOAD_RST;
      req_q <= `IHS_REQ_RST;
      ack_value_to_send_q <= 1'b0;
      rdata <= `IHS_BYTE_RST;
    end else begin
      if (buf_ok) tx_rx_buffer_q <= wdata;
      else if (rx_done) tx_rx_buffer_q <= shift_q;
      if (wr && (addr == `IHS_OFS_RELOAD)) baud_reload_value_q <= wdata;
      req_q <= (ctrl_ok ? wdata[4:0] : req_q) & ~clr_req;
      if (wr_ctrl) ack_value_to_send_q <= wdata[`IHS_ACK_VALUE];
      rdata <= rd ? rd_mux : `IHS_BYTE_RST;
    end
  end

  // status flags: hardware set wins over a write-one clear
  always_ff @(posedge clock) begin
    if (srst) begin
      buffer_full_flag_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      received_ack_status_q <= 1'b0;
      serial_event_flag_q <= 1'b0;
      bus_collision_flag_q <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else begin
      buffer_full_flag_q <= buf_ok || rx_done ||
                            (buffer_full_flag_q && !full_clr && !(rd && (addr == `IHS_OFS_BUF)));
      write_collision_flag_q <= buf_col || (write_collision_flag_q && !w1c[`IHS_ST_WRCOL]);
      if (ack_ld) received_ack_status_q <= sda_s;
      serial_event_flag_q <= ev_set || (serial_event_flag_q && !w1c[`IHS_ST_EVENT]);
      bus_collision_flag_q <= collide || (bus_collision_flag_q && !w1c[`IHS_ST_BCOL]);
      start_seen_q <= ss_set || (start_seen_q && !w1c[`IHS_ST_START]);
      stop_seen_q <= ps_set || (stop_seen_q && !w1c[`IHS_ST_STOP]);
    end
  end

  // ==========================================================
  // assertions
  a_write_collision_flag_on_busy: assert property (@(posedge clock) disable iff (srst)
    buf_col |=> write_collision_flag_q && $stable(tx_rx_buffer_q)) else $error("busy write not refused");
  a_ctrl_held: assert property (@(posedge clock) disable iff (srst)
    (wr_ctrl && req_q[`IHS_REQ_START]) |=> req_q[`IHS_REQ_START]) else $error("start request lost");
  a_start_low: assert property (@(posedge clock) disable iff (srst)
    (st_q == ihs_pkg::ST_START1 && tmo && scl_s && sda_s) |=> sda_oe && start_seen_q && !scl_oe)
    else $error("start did not drive data low");
  a_start_coll: assert property (@(posedge clock) disable iff (srst)
    (st_q == ihs_pkg::ST_IDLE && req_q[`IHS_REQ_START] && (!scl_s || !sda_s))
    |=> bus_collision_flag_q && req_q == `IHS_REQ_RST && !sda_oe && !scl_oe) else $error("start collision missed");
  a_high_wait: assert property (@(posedge clock) disable iff (srst)
    (st_q == ihs_pkg::ST_TXHIGH && !armed_q && !scl_s) |=> cnt_q == baud_reload_value_q && !armed_q)
    else $error("counter ran with clock held low");
  a_ack_drive: assert property (@(posedge clock) disable iff (srst)
    (st_q == ihs_pkg::ST_A1) |-> scl_oe && (sda_oe == !ack_value_to_send_q)) else $error("ack value not driven");
  a_byte_end: assert property (@(posedge clock) disable iff (srst)
    (st_q == ihs_pkg::ST_TXHIGH && tmo && bit_q == `IHS_ACK_BIT)
    |=> serial_event_flag_q && scl_oe && st_q == ihs_pkg::ST_IDLE [*2]) else $error("ninth clock end wrong");
  a_bf_clear: assert property (@(posedge clock) disable iff (srst)
    (st_q == ihs_pkg::ST_TXHIGH && tmo && bit_q == `IHS_LAST_BIT) |=> !buffer_full_flag_q ##1 !sda_oe)
    else $error("eighth bit end wrong");
  a_stop_done: assert property (@(posedge clock) disable iff (srst)
    (st_q == ihs_pkg::ST_P3 && tmo) |=> !req_q[`IHS_REQ_STOP] && serial_event_flag_q && !sda_oe)
    else $error("stop did not finish");
  a_tx_start: assert property (@(posedge clock) disable iff (srst)
    buf_ok |=> buffer_full_flag_q && scl_oe && st_q == ihs_pkg::ST_TXLOW) else $error("write did not start");
  c_start: cover property (@(posedge clock) st_q == ihs_pkg::ST_START2 && tmo);
  c_byte: cover property (@(posedge clock) st_q == ihs_pkg::ST_TXHIGH && tmo && bit_q == `IHS_ACK_BIT);
  c_stop: cover property (@(posedge clock) ps_set);
  c_coll: cover property (@(posedge clock) collide);
endmodule // ihs_host_sequencer
`default_nettype wire

// ---- ihs_params.svh ----
`ifndef IHS_PARAMS_SVH
`define IHS_PARAMS_SVH

// register offsets
`define IHS_OFS_BUF    2'h0
`define IHS_OFS_RELOAD 2'h1
`define IHS_OFS_CTRL   2'h2
`define IHS_OFS_STAT   2'h3
// reset values
`define IHS_RELOAD_RST 8'h09
`define IHS_BYTE_RST   8'h00
`define IHS_REQ_RST    5'h00
`define IHS_CNT_ZERO   8'h00
// control bit positions
`define IHS_REQ_START  0
`define IHS_REQ_RESTRT 1
`define IHS_REQ_STOP   2
`define IHS_REQ_RECV   3
`define IHS_REQ_ACK    4
`define IHS_ACK_VALUE  5
// status bit positions
`define IHS_ST_FULL    0
`define IHS_ST_WRCOL   1
`define IHS_ST_ACKRX   2
`define IHS_ST_EVENT   3
`define IHS_ST_BCOL    4
`define IHS_ST_START   5
`define IHS_ST_STOP    6
// bit counts within a byte
`define IHS_FIRST_BIT  4'h0
`define IHS_LAST_BIT   4'h7
`define IHS_ACK_BIT    4'h8
`endif

// ---- ihs_pkg.sv ----
`default_nettype none
package ihs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START1, ST_START2, ST_R1, ST_R2, ST_R3, ST_TXLOW, ST_TXHIGH,
    ST_RXLOW, ST_RXHIGH, ST_A1, ST_A2, ST_P1, ST_P2, ST_P3
  } ihs_state_type;
endpackage
`default_nettype wire

// ---- tb_ihs_host_sequencer.sv ----
`default_nettype none
// ==================================================
// bench for the host sequencer
module tb_ihs_host_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0]  data;
    logic        nack;
    logic [15:0] stretch;
  } ihs_row_type;
  localparam logic [7:0] RELOAD = 8'h03; // five clocks low and seven high per bit
  logic        clock, srst, wr, rd, scl_oe, sda_oe, tb_sda_pull;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata, tx_byte, model_rx, n_starts, st, s0;
  logic        scl_pull, sda_pull, nack, host_ack;
  logic [15:0] stretch;
  wire         scl_w, sda_w;
  int          n_fail, compares;
  realtime     t_rise, min_hi;
  ihs_row_type rows [4] = '{'{8'hA0, 1'b0, 16'h0000}, '{8'hA5, 1'b0, 16'h0000},
                            '{8'h3C, 1'b0, 16'h012C}, '{8'hFF, 1'b1, 16'h0000}};
  // wired-and lines with pull-ups
  assign scl_w = !(scl_oe | scl_pull);
  assign sda_w = !(sda_oe | sda_pull | tb_sda_pull);
  ihs_host_sequencer ihs_host_sequencer_inst (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_w), .sda_in(sda_w), .scl_oe(scl_oe), .sda_oe(sda_oe));
  ihs_client_model ihs_client_model_inst (.scl(scl_w), .sda(sda_w), .nack(nack), .stretch_ns(stretch),
    .tx_byte(tx_byte), .scl_pull(scl_pull), .sda_pull(sda_pull), .rx_byte(model_rx),
    .host_ack(host_ack), .n_starts(n_starts));
  // clock
  initial begin
    clock = 1'b0;
    forever #25 clock = !clock;
  end
  // shortest clock high time on the wire
  always @(posedge scl_w) t_rise = $realtime;
  always @(negedge scl_w) if (!srst && $realtime - t_rise < min_hi) min_hi = $realtime - t_rise;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_event(output logic [7:0] s);
    s = 8'h00;
    for (int i = 0; i < 500 && s[3] !== 1'b1; i++)
      rd_reg(2'h3, s);
    check(s & 8'h08, 8'h08);
  endtask
  task automatic send_byte(input ihs_row_type r);
    logic [7:0] s;
    nack    <= r.nack;
    stretch <= r.stretch;
    wr_reg(2'h0, r.data);
    rd_reg(2'h3, s);
    check(s & 8'h01, 8'h01);
    wait_event(s);
    check(model_rx, r.data);
    check(s, {5'h01, r.nack, 2'h0});
    repeat (10) @(posedge clock);
    check({6'h0, scl_w, scl_oe}, 8'h01);
    wr_reg(2'h3, 8'h7A);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    $display("watchdog ran out at %0t", $time);
    end_sim();
  end
  // ==================================================
  // main sequence
  initial begin
    srst = 1'b1; addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; tb_sda_pull = 1'b0;
    nack = 1'b0; stretch = 16'h0; tx_byte = 8'h96; n_fail = 0; compares = 0; min_hi = 1.0e9;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    rd_reg(2'h1, st);
    check(st, 8'h09);
    rd_reg(2'h3, st);
    check(st, 8'h00);
    wr_reg(2'h1, RELOAD);
    rd_reg(2'h1, st);
    check(st, RELOAD);
    $display("test reset done");
    // start with the data line held low from outside
    @(posedge clock);
    tb_sda_pull <= 1'b1;
    wr_reg(2'h2, 8'h01);
    repeat (8) @(posedge clock);
    rd_reg(2'h3, st);
    check(st & 8'h11, 8'h10);
    rd_reg(2'h2, st);
    check(st, 8'h00);
    check({6'h0, scl_oe, sda_oe}, 8'h00);
    tb_sda_pull <= 1'b0;
    repeat (4) @(posedge clock);
    wr_reg(2'h3, 8'h7A);
    $display("test start collision done");
    // start, with a stop request and a buffer write pushed in meanwhile
    wr_reg(2'h2, 8'h01);
    wr_reg(2'h2, 8'h04);
    wr_reg(2'h0, 8'h5E);
    wait_event(st);
    check(st, 8'h2A);
    rd_reg(2'h2, st);
    check(st, 8'h00);
    rd_reg(2'h0, st);
    check(st, 8'h00);
    check({6'h0, scl_w, sda_w}, 8'h02);
    wr_reg(2'h3, 8'h7A);
    $display("test start done");
    // ordinary bytes, one of them with the clock stretched
    foreach (rows[i])
      send_byte(rows[i]);
    check({7'h0, min_hi >= 200.0}, 8'h01);
    $display("test table done");
    // second buffer write and a restart while a byte is on the wire
    nack    <= 1'b0;
    stretch <= 16'h0;
    wr_reg(2'h0, 8'h5A);
    wr_reg(2'h0, 8'h77);
    wr_reg(2'h2, 8'h02);
    wait_event(st);
    check(st, 8'h0A);
    check(model_rx, 8'h5A);
    rd_reg(2'h2, st);
    check(st, 8'h00);
    wr_reg(2'h3, 8'h7A);
    rd_reg(2'h3, st);
    check(st, 8'h00);
    $display("test write collision done");
    // repeated start then a read transfer
    s0 = n_starts;
    wr_reg(2'h2, 8'h02);
    wait_event(st);
    check(st, 8'h28);
    check(n_starts - s0, 8'h01);
    check({6'h0, scl_w, sda_w}, 8'h00);
    wr_reg(2'h3, 8'h7A);
    send_byte('{8'hA1, 1'b0, 16'h0000});
    for (int k = 0; k < 2; k++) begin
      wr_reg(2'h2, 8'h08);
      wait_event(st);
      check(st & 8'hFB, 8'h09);
      rd_reg(2'h0, st);
      check(st, k == 0 ? 8'h96 : 8'h69);
      tx_byte <= 8'h69;
      wr_reg(2'h3, 8'h7A);
      wr_reg(2'h2, {2'h0, k[0], 5'h10});
      wait_event(st);
      check({7'h0, host_ack}, {7'h0, k[0]});
      rd_reg(2'h2, st);
      check(st, {2'h0, k[0], 5'h00});
      wr_reg(2'h3, 8'h7A);
    end
    $display("test read done");
    // stop
    wr_reg(2'h2, 8'h04);
    wait_event(st);
    check(st & 8'hFB, 8'h48);
    check({6'h0, scl_w, sda_w}, 8'h03);
    wr_reg(2'h3, 8'h7A);
    $display("test stop done");
    // reset in mid byte
    wr_reg(2'h2, 8'h01);
    wait_event(st);
    wr_reg(2'h0, 8'hC3);
    repeat (12) @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1 check({6'h0, scl_oe, sda_oe}, 8'h00);
    rd_reg(2'h3, st);
    check(st & 8'hBF, 8'h00);
    rd_reg(2'h1, st);
    check(st, 8'h09);
    $display("test mid reset done");
    end_sim();
  end
endmodule // tb_ihs_host_sequencer
`default_nettype wire
